// *** logic/sps_consts.svh ***
// constants of the serial port pin and select logic
`ifndef SPS_CONSTS_SVH
`define SPS_CONSTS_SVH
`define SPS_CLK_NS 8
`define SPS_SCK_HALF_NS 40
`define SPS_SCK_HALF_CYC ((`SPS_SCK_HALF_NS + `SPS_CLK_NS - 1) / `SPS_CLK_NS)
`define SPS_BITS_PER_BYTE 4'h8
`define SPS_LAST_SLV_BIT 4'h7
`define SPS_MODE_3WIRE 2'h0
`define SPS_MODE_MULTI 2'h1
`define SPS_SHIFT_RST 8'h00
`define SPS_MODE_RST 2'h1
`endif

// *** logic/sps_pkg.sv ***
// types of the serial port pin and select logic
`default_nettype none
package sps_pkg;
  typedef struct packed {
    logic port_enable_bit;
    logic master_enable_bit;
    logic [1:0] select_mode_field;
  } sps_cfg_type;

  typedef enum logic [1:0] {SPS_IDLE, SPS_LOW, SPS_HIGH} sps_mst_state_type;

  // slave selection: 3-wire always, 4-wire slave on low select
  function automatic logic sps_selected(input logic [1:0] mode,
                                        input logic sel_level);
    sps_selected = (mode == 2'h1) ? ~sel_level : 1'b1;
  endfunction
endpackage
`default_nettype wire

// *** logic/sps_sync.sv ***
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module sps_sync (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic d_i,
  output logic q_o
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      q_o <= 1'b0;
    end else begin
      s1_ff <= d_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        q_o <= s3_ff;
      end
    end
  end
endmodule // sps_sync
`default_nettype wire

// *** logic/sps_port.sv ***
// serial peripheral port: pin directions, select modes, byte shifting
// Summary of operation
// - data-out pin driven when master, input when slave
// - master data-out carries shift register msb, msb first
// - data-in pin input when master, output when slave, msb first
// - data-in released when disabled or unselected 4-wire slave
// - 3-wire slave drives data-in continuously from shift msb
// - master generates serial clock; slave takes it from outside
// - unselected 4-wire slave ignores serial clock
// - mode 00: 3-wire, select unused, slave always selected
// - mode 01: select is input, low selects the slave
// - mode 01 master: falling select disables master function
// - mode 1x: select is output following mode low bit
// - select routed to pin except in 3-wire mode
// - multi-master fault clears both enables, raises fault flag
// - 4-wire slave bit counter reset on select falling edge
// - byte-complete flag set at end of every byte
`timescale 1ns/1ps
`default_nettype none
`include "sps_consts.svh"
module sps_port
  import sps_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic cfg_wr_i,
  input wire logic port_enable_bit_i,
  input wire logic master_enable_bit_i,
  input wire logic [1:0] select_mode_field_i,
  input wire logic tx_wr_i,
  input wire logic [7:0] tx_data_i,
  input wire logic byte_complete_clr_i,
  input wire logic mode_fault_clr_i,
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic miso_i,
  input wire logic sel_i,
  output logic sck_o,
  output logic sck_oe_o,
  output logic mosi_o,
  output logic mosi_oe_o,
  output logic miso_o,
  output logic miso_oe_o,
  output logic sel_o,
  output logic sel_oe_o,
  output logic sel_pin_map_o,
  output logic port_enable_bit_o,
  output logic master_enable_bit_o,
  output logic [1:0] select_mode_field_o,
  output logic byte_complete_flag_o,
  output logic mode_fault_flag_o,
  output logic busy_o,
  output logic [7:0] rx_data_o
);
  localparam logic [3:0] HALF_LAST = 4'(`SPS_SCK_HALF_CYC - 1);

  sps_cfg_type cfg_ff;
  sps_mst_state_type mst_state_ff;
  logic [3:0] div_ff;
  logic [3:0] cnt_ff;
  logic [7:0] shift_ff;
  logic sck_f;
  logic mosi_f;
  logic miso_f;
  logic sel_f;
  logic sck_prev_ff;
  logic sel_prev_ff;
  logic mst_tick;
  logic mst_start;
  logic mst_done;
  logic slv_active;
  logic slv_rise;
  logic slv_done;
  logic sel_fall;
  logic fault_evt;
  logic byte_done;
  logic is_master;

  sps_sync u_sync_sck (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .d_i(sck_i), .q_o(sck_f));
  sps_sync u_sync_mosi (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .d_i(mosi_i), .q_o(mosi_f));
  sps_sync u_sync_miso (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .d_i(miso_i), .q_o(miso_f));
  sps_sync u_sync_sel (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .d_i(sel_i), .q_o(sel_f));

  always_comb begin
    is_master = cfg_ff.port_enable_bit & cfg_ff.master_enable_bit;
    sel_fall = sel_prev_ff & ~sel_f;
    fault_evt = is_master & sel_fall &
                (cfg_ff.select_mode_field == `SPS_MODE_MULTI);
    mst_tick = (mst_state_ff != SPS_IDLE) & (div_ff == HALF_LAST);
    mst_start = tx_wr_i & is_master & (mst_state_ff == SPS_IDLE);
    mst_done = mst_tick & (mst_state_ff == SPS_HIGH) &
               (cnt_ff == `SPS_BITS_PER_BYTE);
    slv_active = cfg_ff.port_enable_bit & ~cfg_ff.master_enable_bit &
                 sps_selected(cfg_ff.select_mode_field, sel_f);
    slv_rise = slv_active & sck_f & ~sck_prev_ff;
    slv_done = slv_rise & (cnt_ff == `SPS_LAST_SLV_BIT);
    byte_done = mst_done | slv_done;
  end

  // configuration; a fault overrides a software write
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_ff <= '{1'b0, 1'b0, `SPS_MODE_RST};
    end else if (fault_evt) begin
      cfg_ff.port_enable_bit <= 1'b0;
      cfg_ff.master_enable_bit <= 1'b0;
    end else if (cfg_wr_i) begin
      cfg_ff <= '{port_enable_bit_i, master_enable_bit_i,
                  select_mode_field_i};
    end
  end

  // edge history of synchronised pins
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sck_prev_ff <= 1'b0;
      sel_prev_ff <= 1'b1;
    end else begin
      sck_prev_ff <= sck_f;
      sel_prev_ff <= sel_f;
    end
  end

  // master serial clock generation
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mst_state_ff <= SPS_IDLE;
      div_ff <= 4'h0;
      sck_o <= 1'b0;
    end else if (!is_master) begin
      mst_state_ff <= SPS_IDLE;
      div_ff <= 4'h0;
      sck_o <= 1'b0;
    end else begin
      div_ff <= mst_tick ? 4'h0 : div_ff + 4'h1;
      case (mst_state_ff)
        SPS_IDLE: begin
          div_ff <= 4'h0;
          if (mst_start) begin
            mst_state_ff <= SPS_LOW;
          end
        end
        SPS_LOW: begin
          if (mst_tick) begin
            sck_o <= 1'b1;
            mst_state_ff <= SPS_HIGH;
          end
        end
        SPS_HIGH: begin
          if (mst_tick) begin
            sck_o <= 1'b0;
            mst_state_ff <= mst_done ? SPS_IDLE : SPS_LOW;
          end
        end
        default: begin
          mst_state_ff <= SPS_IDLE;
        end
      endcase
    end
  end

  // shift register and bit counter for both roles
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shift_ff <= `SPS_SHIFT_RST;
      cnt_ff <= 4'h0;
      rx_data_o <= `SPS_SHIFT_RST;
    end else if (!cfg_ff.port_enable_bit) begin
      cnt_ff <= 4'h0;
    end else if (mst_start) begin
      shift_ff <= tx_data_i;
      cnt_ff <= 4'h0;
    end else if (is_master) begin
      if (mst_tick && mst_state_ff == SPS_LOW) begin
        shift_ff <= {shift_ff[6:0], miso_f};
        cnt_ff <= cnt_ff + 4'h1;
      end
      if (mst_done) begin
        rx_data_o <= shift_ff;
        cnt_ff <= 4'h0;
      end
    end else if (sel_fall &&
                 cfg_ff.select_mode_field == `SPS_MODE_MULTI) begin
      cnt_ff <= 4'h0;
    end else if (slv_rise) begin
      shift_ff <= {shift_ff[6:0], mosi_f};
      cnt_ff <= slv_done ? 4'h0 : cnt_ff + 4'h1;
      if (slv_done) begin
        rx_data_o <= {shift_ff[6:0], mosi_f};
      end
    end else if (tx_wr_i && cnt_ff == 4'h0) begin
      shift_ff <= tx_data_i;
    end
  end

  // sticky flags: a set wins over a clear in the same cycle
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      byte_complete_flag_o <= 1'b0;
      mode_fault_flag_o <= 1'b0;
    end else begin
      byte_complete_flag_o <= byte_done |
        (byte_complete_flag_o & ~byte_complete_clr_i);
      mode_fault_flag_o <= fault_evt |
        (mode_fault_flag_o & ~mode_fault_clr_i);
    end
  end

  // pin drive and status outputs
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sck_oe_o <= 1'b0;
      mosi_o <= 1'b0;
      mosi_oe_o <= 1'b0;
      miso_o <= 1'b0;
      miso_oe_o <= 1'b0;
      sel_o <= 1'b1;
      sel_oe_o <= 1'b0;
      sel_pin_map_o <= 1'b0;
      port_enable_bit_o <= 1'b0;
      master_enable_bit_o <= 1'b0;
      select_mode_field_o <= `SPS_MODE_RST;
      busy_o <= 1'b0;
    end else begin
      sck_oe_o <= is_master;
      mosi_o <= shift_ff[7];
      mosi_oe_o <= is_master;
      miso_o <= shift_ff[7];
      miso_oe_o <= slv_active;
      sel_o <= cfg_ff.select_mode_field[0];
      sel_oe_o <= cfg_ff.select_mode_field[1];
      sel_pin_map_o <= (cfg_ff.select_mode_field != `SPS_MODE_3WIRE);
      port_enable_bit_o <= cfg_ff.port_enable_bit;
      master_enable_bit_o <= cfg_ff.master_enable_bit;
      select_mode_field_o <= cfg_ff.select_mode_field;
      busy_o <= (mst_state_ff != SPS_IDLE) | (cnt_ff != 4'h0);
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  a_fault_clears_en: assert property (fault_evt |=>
    !cfg_ff.port_enable_bit && !cfg_ff.master_enable_bit ##1
    !port_enable_bit_o && !master_enable_bit_o)
    else $error("fault did not clear enables");
  a_fault_raises_flag: assert property (fault_evt |=> mode_fault_flag_o)
    else $error("fault flag not raised");
  a_mosi_slave_input: assert property (!is_master |=> !mosi_oe_o)
    else $error("data-out driven while not master");
  a_mosi_msb_out: assert property (is_master && $rose(shift_ff[7])
    |=> mosi_o)
    else $error("data-out not shift msb");
  a_miso_release: assert property (!cfg_ff.port_enable_bit
    |=> !miso_oe_o)
    else $error("data-in driven while disabled");
  a_miso_3wire_drive: assert property (cfg_ff.port_enable_bit &&
    !cfg_ff.master_enable_bit && cfg_ff.select_mode_field == 2'h0
    |=> miso_oe_o && miso_o == $past(shift_ff[7]))
    else $error("3-wire slave not driving data-in");
  a_sck_ignored: assert property (cfg_ff.port_enable_bit &&
    !cfg_ff.master_enable_bit && cfg_ff.select_mode_field == 2'h1 &&
    sel_f && sel_prev_ff && !tx_wr_i |=> $stable(cnt_ff) && $stable(shift_ff))
    else $error("unselected slave reacted to clock");
  a_sel_output: assert property (cfg_ff.select_mode_field[1]
    |=> sel_oe_o && sel_o == $past(cfg_ff.select_mode_field[0]))
    else $error("select output wrong");
  a_sel_unmapped: assert property (cfg_ff.select_mode_field == 2'h0
    |=> !sel_pin_map_o)
    else $error("select mapped in 3-wire mode");
  a_cnt_sel_fall: assert property (cfg_ff.port_enable_bit &&
    !cfg_ff.master_enable_bit && cfg_ff.select_mode_field == 2'h1 &&
    sel_fall |=> cnt_ff == 4'h0)
    else $error("bit counter not reset on select fall");
  a_byte_flag_set: assert property (byte_done |=> byte_complete_flag_o
    ##0 rx_data_o == $past(mst_done ? shift_ff :
    {shift_ff[6:0], mosi_f}))
    else $error("byte complete not flagged");
  a_master_byte_len: assert property (mst_start |->
    ##[80:82] byte_complete_flag_o)
    else $error("master byte length wrong");
endmodule // sps_port
`default_nettype wire

// *** testbench/sps_far_model.sv ***
// far-side serial device: slave to a master port, master to a slave port
`timescale 1ns/1ps
`default_nettype none
module sps_far_model (
  input wire logic clk_sys_i,
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic miso_i,
  output logic sck_o,
  output logic mosi_o,
  output logic miso_o,
  output logic sel_o
);
  logic drv = 1'b0;
  logic mosi_q = 1'b0;
  logic [7:0] tx_sh = 8'h00;
  logic [7:0] rx_sh = 8'h00;
  initial begin
    sck_o = 1'b0;
    mosi_o = 1'b0;
    sel_o = 1'b1;
  end
  assign miso_o = tx_sh[7];
  // data line seen half a cycle before the clock rise
  always @(negedge clk_sys_i) mosi_q <= mosi_i;
  always @(posedge sck_i) begin
    if (!drv) begin
      rx_sh <= {rx_sh[6:0], mosi_q};
      tx_sh <= {tx_sh[6:0], ~tx_sh[7]};
    end
  end
  // idle-low clock, 40 ns halves, stands still outside frames
  // n bits from the msb; fewer than eight leave a cut frame
  task automatic send(input logic [7:0] b, input logic sel_low,
                      input int n, output logic [7:0] got);
    drv = 1'b1;
    sel_o = ~sel_low;
    #24;
    for (int i = 7; i > 7 - n; i--) begin
      mosi_o = b[i];
      #40;
      got = {got[6:0], miso_i};
      sck_o = 1'b1;
      #40;
      sck_o = 1'b0;
    end
    mosi_o = ~mosi_o;
    #40;
    sel_o = 1'b1;
    drv = 1'b0;
  endtask
endmodule // sps_far_model
`default_nettype wire

// *** testbench/tb_top.sv ***
// bench for the serial port pin and select logic
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import sps_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic cfg_wr_i = 1'b0;
  sps_cfg_type cfg = '0;
  logic tx_wr_i = 1'b0;
  logic [7:0] tx_data_i = 8'h00;
  logic byte_complete_clr_i = 1'b0;
  logic mode_fault_clr_i = 1'b0;
  logic sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o;
  logic sel_o, sel_oe_o, sel_pin_map_o, port_enable_bit_o;
  logic master_enable_bit_o, byte_complete_flag_o, mode_fault_flag_o;
  logic busy_o;
  logic [1:0] select_mode_field_o;
  logic [7:0] rx_data_o;
  logic f_sck, f_mosi, f_miso, f_sel;
  wire logic sck_pin = sck_oe_o ? sck_o : f_sck;
  wire logic mosi_pin = mosi_oe_o ? mosi_o : f_mosi;
  wire logic miso_pin = miso_oe_o ? miso_o : f_miso;
  wire logic sel_pin = sel_oe_o ? sel_o : f_sel;
  int bad_count = 0;
  int tests_run = 0;
  int cyc = 0;
  sps_port u_sps_port (
    .clk_sys_i, .rstn_i, .cfg_wr_i,
    .port_enable_bit_i(cfg.port_enable_bit),
    .master_enable_bit_i(cfg.master_enable_bit),
    .select_mode_field_i(cfg.select_mode_field),
    .tx_wr_i, .tx_data_i, .byte_complete_clr_i, .mode_fault_clr_i,
    .sck_i(sck_pin), .mosi_i(mosi_pin), .miso_i(miso_pin), .sel_i(sel_pin),
    .sck_o, .sck_oe_o, .mosi_o, .mosi_oe_o, .miso_o, .miso_oe_o,
    .sel_o, .sel_oe_o, .sel_pin_map_o, .port_enable_bit_o,
    .master_enable_bit_o, .select_mode_field_o, .byte_complete_flag_o,
    .mode_fault_flag_o, .busy_o, .rx_data_o
  );
  sps_far_model u_sps_far_model (
    .clk_sys_i, .sck_i(sck_pin), .mosi_i(mosi_pin), .miso_i(miso_pin),
    .sck_o(f_sck), .mosi_o(f_mosi), .miso_o(f_miso), .sel_o(f_sel)
  );
  always #4 clk_sys_i = ~clk_sys_i;
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                     input string what);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic set_cfg(input logic en, input logic ms, input logic [1:0] md);
    cfg = {en, ms, md};
    cfg_wr_i = 1'b1;
    step(1);
    cfg_wr_i = 1'b0;
    step(2);
  endtask
  task automatic clr();
    byte_complete_clr_i = 1'b1;
    mode_fault_clr_i = 1'b1;
    step(1);
    byte_complete_clr_i = 1'b0;
    mode_fault_clr_i = 1'b0;
  endtask
  task automatic load(input logic [7:0] b);
    tx_data_i = b;
    tx_wr_i = 1'b1;
    step(1);
    tx_wr_i = 1'b0;
  endtask
  task automatic mst_byte(input logic [7:0] tx, input logic [7:0] fin);
    clr();
    u_sps_far_model.tx_sh = fin;
    load(tx);
    step(81);
    chk(byte_complete_flag_o, 1, "mst flag");
    chk(rx_data_o, fin, "mst rx");
    chk(u_sps_far_model.rx_sh, tx, "mst tx");
  endtask
  task automatic slv_byte(input logic [7:0] pre, input logic [7:0] b,
                          input logic sel_low);
    logic [7:0] got;
    clr();
    load(pre);
    u_sps_far_model.send(b, sel_low, 8, got);
    step(8);
    chk(byte_complete_flag_o, 1, "slv flag");
    chk(rx_data_o, b, "slv rx");
    chk(got, pre, "slv tx");
  endtask
  task automatic results();
    if (bad_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      results();
    end
  end
  initial begin
    logic [7:0] got;
    step(5);
    rstn_i = 1'b1;
    step(1);
    chk(miso_oe_o, 0, "rst miso oe");
    chk(select_mode_field_o, 2'h1, "rst mode");
    set_cfg(1'b1, 1'b1, 2'h0);
    chk(sel_pin_map_o, 0, "3w map");
    chk(mosi_oe_o, 1, "mst mosi oe");
    chk(miso_oe_o, 0, "mst miso oe");
    chk(sck_oe_o, 1, "mst sck oe");
    mst_byte(8'ha5, 8'h3c);
    set_cfg(1'b1, 1'b1, 2'h2);
    chk(sel_oe_o, 1, "1x sel oe");
    chk(sel_o, 0, "1x sel lvl");
    chk(sel_pin_map_o, 1, "1x map");
    mst_byte(8'h81, 8'h7e);
    set_cfg(1'b1, 1'b1, 2'h3);
    chk(sel_o, 1, "1x sel hi");
    set_cfg(1'b1, 1'b0, 2'h0);
    chk(miso_oe_o, 1, "3w slv oe");
    chk(mosi_oe_o, 0, "slv mosi oe");
    chk(sck_oe_o, 0, "slv sck oe");
    slv_byte(8'h96, 8'h5a, 1'b0);
    set_cfg(1'b1, 1'b0, 2'h1);
    clr();
    chk(miso_oe_o, 0, "4w unsel oe");
    u_sps_far_model.send(8'hff, 1'b0, 8, got);
    step(8);
    chk(byte_complete_flag_o, 0, "unsel flag");
    chk(busy_o, 0, "unsel busy");
    u_sps_far_model.send(8'h5f, 1'b1, 3, got);
    step(8);
    chk(busy_o, 1, "cut busy");
    u_sps_far_model.send(8'h69, 1'b1, 8, got);
    step(8);
    chk(rx_data_o, 8'h69, "resync rx");
    slv_byte(8'hc3, 8'h3c, 1'b1);
    set_cfg(1'b1, 1'b1, 2'h1);
    clr();
    u_sps_far_model.sel_o = 1'b0;
    step(8);
    chk(mode_fault_flag_o, 1, "fault flag");
    chk(port_enable_bit_o, 0, "fault en");
    chk(master_enable_bit_o, 0, "fault mst");
    chk(mosi_oe_o, 0, "fault mosi oe");
    clr();
    chk(mode_fault_flag_o, 0, "fault clr");
    u_sps_far_model.sel_o = 1'b1;
    set_cfg(1'b0, 1'b0, 2'h0);
    chk(miso_oe_o, 0, "off miso oe");
    results();
  end
endmodule // tb_top
`default_nettype wire
